// ===== hdl/pdc_core.sv
/*
 * Digital core of a PLL synthesizer: serial loading port, reference and
 * VCO-input dividers with monitor outputs, single and double-ended phase
 * detectors, lock indicator and reference clock output divider.
 * It assumes all pins are synchronous to mclk, and that the reference and
 * VCO inputs are well below half the mclk rate so edges are seen.
 */
module pdc_core (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic serial_clk,
    input  wire logic serial_data,
    input  wire logic serial_select_n,
    input  wire logic reference_input,
    input  wire logic vco_input,
    output logic      ref_div_monitor,
    output logic      vco_div_monitor,
    output logic      reference_clock_output,
    output logic      single_ended_detector_out,
    output logic      single_ended_detector_oe,
    output logic      ref_side_detector_n,
    output logic      vco_side_detector_n,
    output logic      lock_indicator_out
);
    // Registers loaded over the serial port.
    logic [7:0]  loop_configuration;
    logic [15:0] vco_ratio;
    logic [14:0] ref_ratio;
    // Serial shift register and clock count for the frame in progress.
    logic [23:0] shifter;
    logic [5:0]  bit_count;
    // Previous samples for edge detection.
    logic        clk_q;
    logic        sel_q;
    logic        ref_q;
    logic        vco_q;
    // One-cycle load strobes.
    logic        load_vco;
    // Edge pulses.
    logic        ref_rise;
    logic        ref_edge;
    logic        vco_rise;
    // Divider terminal pulses.
    logic        ref_term;
    logic        vco_term;
    // Detector state: up and down flip-flops.
    logic        ref_ahead;
    logic        vco_ahead;
    // Monitor pulse stretcher, in reference half cycles.
    logic [3:0]  mon_left;
    // Reference output divider counter.
    logic [3:0]  refclk_count;
    // Configuration fields.
    logic        detector_inversion;
    logic        detector_select;
    logic        lock_indicator_enable;
    logic [2:0]  refclk_divide_select;
    logic        vco_monitor_enable;
    logic        ref_monitor_enable;
    // Effective reference pulse into the detectors.
    logic        ref_event;
    logic        bypass;
    logic        ref_lead_n;
    logic        vco_lead_n;
    logic        ser_rise;
    logic        sel_rise;

    assign detector_inversion    = loop_configuration[pdc_pkg::CFG_INV_BIT];
    assign detector_select       = loop_configuration[pdc_pkg::CFG_SEL_BIT];
    assign lock_indicator_enable = loop_configuration[pdc_pkg::CFG_LOCK_BIT];
    assign refclk_divide_select  =
        loop_configuration[pdc_pkg::CFG_REFSEL_HI:pdc_pkg::CFG_REFSEL_LO];
    assign vco_monitor_enable    = loop_configuration[pdc_pkg::CFG_VMON_BIT];
    assign ref_monitor_enable    = loop_configuration[pdc_pkg::CFG_RMON_BIT];

    // Keep last samples of every pin that is edge-detected.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clk_q <= 1'b0;
            sel_q <= 1'b1;
            ref_q <= 1'b0;
            vco_q <= 1'b0;
        end else begin
            clk_q <= serial_clk;
            sel_q <= serial_select_n;
            ref_q <= reference_input;
            vco_q <= vco_input;
        end
    end

    assign ser_rise = serial_clk && !clk_q;
    assign sel_rise = serial_select_n && !sel_q;
    assign ref_rise = reference_input && !ref_q;
    assign ref_edge = reference_input != ref_q;
    assign vco_rise = vco_input && !vco_q;

    // Shift in data MSB first while select is low; count clocks.
    always_ff @(posedge mclk) begin
        if (sys_rst || serial_select_n) begin
            bit_count <= 6'h00;
        end else if (ser_rise) begin
            shifter <= {shifter[22:0], serial_data};
            if (bit_count != pdc_pkg::LEN_MAX + 6'h01) begin
                bit_count <= bit_count + 6'h01;
            end
        end
    end

    // On select rising, load the register that the frame length picks.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            loop_configuration <= pdc_pkg::CFG_RESET;
            vco_ratio          <= pdc_pkg::VCO_RESET;
            ref_ratio          <= pdc_pkg::REF_RESET;
        end else if (sel_rise) begin
            if (bit_count == pdc_pkg::LEN_CFG) begin
                loop_configuration <= shifter[7:0];
            end else if (bit_count == pdc_pkg::LEN_VCO) begin
                vco_ratio <= shifter[15:0];
            end else if (bit_count == pdc_pkg::LEN_REF_S ||
                         bit_count == pdc_pkg::LEN_REF_L) begin
                ref_ratio <= shifter[14:0];
            end else if (bit_count >= pdc_pkg::LEN_RST_LO &&
                         bit_count <= pdc_pkg::LEN_RST_HI) begin
                loop_configuration <= pdc_pkg::CFG_RESET;
                vco_ratio          <= pdc_pkg::VCO_RESET;
                ref_ratio          <= pdc_pkg::REF_RESET;
            end
        end
    end

    // A VCO ratio load restarts both dividers and the detector.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            load_vco <= 1'b0;
        end else begin
            load_vco <= sel_rise && (bit_count == pdc_pkg::LEN_VCO ||
                        (bit_count >= pdc_pkg::LEN_RST_LO &&
                         bit_count <= pdc_pkg::LEN_RST_HI));
        end
    end

    // Reference divider, counting reference rising edges.
    pdc_divider #(.WIDTH(15)) u_ref_div (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .jam      (load_vco),
        .ratio    (ref_ratio),
        .count    (ref_rise),
        .terminal (ref_term)
    );

    // VCO-input divider.
    pdc_divider #(.WIDTH(16)) u_vco_div (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .jam      (load_vco),
        .ratio    (vco_ratio),
        .count    (vco_rise),
        .terminal (vco_term)
    );

    assign bypass    = ref_ratio == 15'h0001;
    assign ref_event = bypass ? ref_rise : ref_term;

    // Stretch the reference terminal pulse to 4.5 input cycles.
    always_ff @(posedge mclk) begin
        if (sys_rst || load_vco) begin
            mon_left <= 4'h0;
        end else if (ref_term) begin
            mon_left <= pdc_pkg::MON_HALF_CYCLES;
        end else if (ref_edge && mon_left != 4'h0) begin
            mon_left <= mon_left - 4'h1;
        end
    end

    // Monitor outputs, gated by their enable bits.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ref_div_monitor <= 1'b0;
            vco_div_monitor <= 1'b0;
        end else begin
            ref_div_monitor <= ref_monitor_enable &&
                (bypass ? reference_input : (mon_left != 4'h0));
            vco_div_monitor <= vco_monitor_enable && vco_term;
        end
    end

    // Phase-frequency detector: the side arriving first sets its flag;
    // the second arrival clears both, so a clear never loses to a set.
    always_ff @(posedge mclk) begin
        if (sys_rst || load_vco) begin
            ref_ahead <= 1'b0;
            vco_ahead <= 1'b0;
        end else if (ref_event && vco_term) begin
            ref_ahead <= 1'b0;
            vco_ahead <= 1'b0;
        end else if (ref_event) begin
            ref_ahead <= !vco_ahead;
            vco_ahead <= 1'b0;
        end else if (vco_term) begin
            vco_ahead <= !ref_ahead;
            ref_ahead <= 1'b0;
        end
    end

    // Lead indications, low active, with simultaneity as a short low on
    // both sides for one cycle.
    assign vco_lead_n = !(vco_ahead || (ref_event && vco_term));
    assign ref_lead_n = !(ref_ahead || (ref_event && vco_term));

    // Detector outputs registered from the flags and the config.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            single_ended_detector_out <= 1'b0;
            single_ended_detector_oe  <= 1'b0;
            ref_side_detector_n       <= 1'b1;
            vco_side_detector_n       <= 1'b1;
        end else if (detector_select) begin
            ref_side_detector_n <= 1'b1;
            vco_side_detector_n <= 1'b1;
            single_ended_detector_oe  <= vco_ahead || ref_ahead;
            single_ended_detector_out <=
                ref_ahead ^ detector_inversion;
        end else begin
            single_ended_detector_oe  <= 1'b0;
            single_ended_detector_out <= 1'b0;
            ref_side_detector_n <= detector_inversion ? vco_lead_n
                                                      : ref_lead_n;
            vco_side_detector_n <= detector_inversion ? ref_lead_n
                                                      : vco_lead_n;
        end
    end

    // Lock output: low while either side leads, forced low when disabled.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            lock_indicator_out <= 1'b0;
        end else begin
            lock_indicator_out <= lock_indicator_enable &&
                !(vco_ahead || ref_ahead);
        end
    end

    // Free-running reference output divider counter.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            refclk_count <= 4'h0;
        end else if (ref_rise) begin
            refclk_count <= refclk_count + 4'h1;
        end
    end

    // Reference clock output selection.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reference_clock_output <= 1'b0;
        end else begin
            unique case (refclk_divide_select)
                pdc_pkg::RSEL_OFF: reference_clock_output <= 1'b0;
                pdc_pkg::RSEL_D1:  reference_clock_output <= reference_input;
                pdc_pkg::RSEL_D2:  reference_clock_output <= refclk_count[0];
                pdc_pkg::RSEL_D4:  reference_clock_output <= refclk_count[1];
                pdc_pkg::RSEL_D8,
                pdc_pkg::RSEL_D8B: reference_clock_output <= refclk_count[2];
                default:           reference_clock_output <= refclk_count[3];
            endcase
        end
    end

    // Checks.
    a_cfg_powerup: assert property (@(posedge mclk)
        $fell(sys_rst) |-> loop_configuration == pdc_pkg::CFG_RESET)
        else $error("configuration not at power-up value");
    a_lock_disabled: assert property (@(posedge mclk)
        disable iff (sys_rst)
        !lock_indicator_enable |=> !lock_indicator_out)
        else $error("lock output not forced low");
    a_pair_static: assert property (@(posedge mclk)
        disable iff (sys_rst)
        detector_select |=> ref_side_detector_n && vco_side_detector_n)
        else $error("double-ended pair not held high");
    a_single_float: assert property (@(posedge mclk)
        disable iff (sys_rst)
        !detector_select |=> !single_ended_detector_oe)
        else $error("single-ended output driven while deselected");
    a_vmon_gate: assert property (@(posedge mclk)
        disable iff (sys_rst)
        !vco_monitor_enable |=> !vco_div_monitor)
        else $error("VCO monitor not held low");
    // A jam in the same cycle as the terminal pulse clears the stretch,
    // so only an undisturbed terminal pulse must start it.
    a_rmon_width: assert property (@(posedge mclk)
        disable iff (sys_rst)
        ref_term && !load_vco |=> mon_left == pdc_pkg::MON_HALF_CYCLES)
        else $error("reference monitor stretch not started");
    a_cfg_only: assert property (@(posedge mclk)
        disable iff (sys_rst)
        sel_rise && bit_count == pdc_pkg::LEN_CFG
        |=> $stable(vco_ratio) && $stable(ref_ratio))
        else $error("eight-clock frame touched a ratio");
    a_jam_load: assert property (@(posedge mclk)
        disable iff (sys_rst)
        sel_rise && bit_count == pdc_pkg::LEN_VCO |=> load_vco)
        else $error("VCO load did not jam dividers");
    a_bypass_copy: assert property (@(posedge mclk)
        disable iff (sys_rst)
        bypass && ref_monitor_enable
        |=> ref_div_monitor == $past(reference_input))
        else $error("bypassed reference not copied to monitor");
    a_rmon_gate: assert property (@(posedge mclk)
        disable iff (sys_rst)
        !ref_monitor_enable |=> !ref_div_monitor)
        else $error("reference monitor not held low");
    a_vmon_single: assert property (@(posedge mclk)
        disable iff (sys_rst)
        vco_div_monitor |=> !vco_div_monitor)
        else $error("VCO monitor pulse wider than one cycle");
    a_rclk_off: assert property (@(posedge mclk)
        disable iff (sys_rst)
        refclk_divide_select == pdc_pkg::RSEL_OFF |=> !reference_clock_output)
        else $error("reference clock output not static low");
    // Main scenarios that the bench is expected to reach.
    c_cfg_load: cover property (@(posedge mclk)
        sel_rise && bit_count == pdc_pkg::LEN_CFG);
    c_ref_load: cover property (@(posedge mclk)
        sel_rise && bit_count == pdc_pkg::LEN_REF_L);
    c_lock_high: cover property (@(posedge mclk) lock_indicator_out);
    c_jam_load: cover property (@(posedge mclk) load_vco);
    c_bypass_event: cover property (@(posedge mclk) bypass && ref_term);
endmodule : pdc_core

// ===== hdl/pdc_divider.sv
/*
 * Programmable down-counting divider, used for both the reference and the
 * VCO-input chains. It assumes that the count input is already a one-cycle
 * pulse per rising edge of the divided signal, in the mclk domain.
 */
module pdc_divider #(
    parameter int WIDTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             jam,
    input  wire logic [WIDTH-1:0] ratio,
    input  wire logic             count,
    output logic                  terminal
);
    // Present count value.
    logic [WIDTH-1:0] remaining;

    // Refuse widths that the reload compare cannot serve; caught at
    // elaboration so a bad instance never builds.
    if (WIDTH < 2) begin : g_width_check
        $error("pdc_divider: WIDTH below 2");
    end

    // Count down once per input edge and reload at one; jam restarts.
    always_ff @(posedge mclk) begin
        if (sys_rst || jam) begin
            remaining <= ratio;
        end else if (count) begin
            if (remaining <= WIDTH'(1)) begin
                remaining <= ratio;
            end else begin
                remaining <= remaining - WIDTH'(1);
            end
        end
    end

    // One pulse per completed period.
    always_ff @(posedge mclk) begin
        if (sys_rst || jam) begin
            terminal <= 1'b0;
        end else begin
            terminal <= count && (remaining <= WIDTH'(1));
        end
    end
endmodule : pdc_divider

// ===== hdl/pdc_pkg.sv
/*
 * Shared constants for the synthesizer divider and detector core: the
 * configuration field positions, their power-up value, the serial frame
 * lengths, the divide-ratio limits and the reference clock output codes.
 * It assumes that every file using it names each item as pdc_pkg::name.
 */
package pdc_pkg;
    // Configuration field positions.
    localparam int CFG_INV_BIT     = 7;
    localparam int CFG_SEL_BIT     = 6;
    localparam int CFG_LOCK_BIT    = 5;
    localparam int CFG_REFSEL_HI   = 4;
    localparam int CFG_REFSEL_LO   = 2;
    localparam int CFG_VMON_BIT    = 1;
    localparam int CFG_RMON_BIT    = 0;
    // Power-up configuration: output divider at /8, all else cleared.
    localparam logic [7:0] CFG_RESET = 8'h10;
    // Serial frame lengths that select a target register.
    localparam logic [5:0] LEN_CFG    = 6'h08;
    localparam logic [5:0] LEN_VCO    = 6'h10;
    localparam logic [5:0] LEN_REF_S  = 6'h0f;
    localparam logic [5:0] LEN_REF_L  = 6'h18;
    localparam logic [5:0] LEN_RST_LO = 6'h09;
    localparam logic [5:0] LEN_RST_HI = 6'h0d;
    localparam logic [5:0] LEN_MAX    = 6'h20;
    // Divide ratio limits and power-up ratios.
    localparam logic [14:0] REF_MIN    = 15'h0005;
    localparam logic [15:0] VCO_MIN    = 16'h0028;
    localparam logic [14:0] REF_RESET  = 15'h0005;
    localparam logic [15:0] VCO_RESET  = 16'h0028;
    // Monitor pulse: 4.5 reference cycles, counted in half cycles.
    localparam logic [3:0] MON_HALF_CYCLES = 4'h9;
    // Reference clock output divider settings.
    localparam logic [2:0] RSEL_OFF = 3'h0;
    localparam logic [2:0] RSEL_D1  = 3'h1;
    localparam logic [2:0] RSEL_D2  = 3'h2;
    localparam logic [2:0] RSEL_D4  = 3'h3;
    localparam logic [2:0] RSEL_D8  = 3'h4;
    localparam logic [2:0] RSEL_D16 = 3'h5;
    localparam logic [2:0] RSEL_D8B = 3'h6;
endpackage : pdc_pkg

// ===== tb/pdc_mcu_model.sv
/*
 * Behavioural controller for the three-wire loading port of the core.
 * It assumes the bench raises start for one mclk cycle while busy is low,
 * with len and word held steady until busy falls again.
 */
module pdc_mcu_model (
    input  wire logic        mclk,
    input  wire logic        start,
    input  wire logic [5:0]  len,
    input  wire logic [23:0] word,
    output logic             busy,
    output logic             serial_clk,
    output logic             serial_data,
    output logic             serial_select_n
);
    timeunit 1ns;
    timeprecision 100ps;

    // Sends the low len bits of word, most significant first, one frame
    // per start; the clock is low whenever the select line moves.
    initial begin
        busy = 1'b0;
        serial_clk = 1'b0;
        serial_data = 1'b0;
        serial_select_n = 1'b1;
        forever begin
            @(posedge mclk);
            if (start) begin
                #1;
                busy = 1'b1;
                serial_select_n = 1'b0;
                for (int i = 23; i >= 0; i--) begin
                    if (i < len) begin
                        serial_data = word[i];
                        serial_clk = 1'b0;
                        repeat (2) @(posedge mclk);
                        #1;
                        serial_clk = 1'b1;
                        repeat (2) @(posedge mclk);
                        #1;
                    end
                end
                serial_clk = 1'b0;
                @(posedge mclk);
                #1;
                serial_select_n = 1'b1;
                busy = 1'b0;
            end else begin
                // An idle data line carries no value, so it keeps moving.
                #1 serial_data = ~serial_data;
            end
        end
    end
endmodule // pdc_mcu_model

// ===== tb/tb_pll_divider_phase_detect_core.sv
/*
 * Self-checking bench for the divider and detector core.
 * It assumes pdc_core and the controller model pdc_mcu_model are compiled.
 */
module tb_pll_divider_phase_detect_core;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        reference_input = 1'b0;
    logic        vco_input = 1'b0;
    logic        start = 1'b0;
    logic [5:0]  len = 6'h00;
    logic [23:0] word = 24'h000000;
    logic        busy, serial_clk, serial_data, serial_select_n;
    logic        rmon, vmon, rclk, se_out, se_oe, ref_n, vco_n, lock;
    int          rh = 4;           // Reference half period in mclk cycles.
    int          err_count = 0;
    int          comparisons = 0;
    int          rl, vl, sh, sl, oe, lk, mon;
    logic [31:0] per, hi;          // Last measured period and high time.
    logic [15:0] seed = 16'h0017;  // Random source, fixed start.
    logic [14:0] rr;
    logic [15:0] vr;

    // Clock and the two divided inputs, both slow against mclk.
    always #2 mclk = ~mclk;
    always begin
        repeat (rh) @(posedge mclk);
        #1 reference_input = ~reference_input;
    end
    always begin
        repeat (2) @(posedge mclk);
        #1 vco_input = ~vco_input;
    end

    pdc_mcu_model mcu (.mclk(mclk), .start(start), .len(len), .word(word),
        .busy(busy), .serial_clk(serial_clk), .serial_data(serial_data),
        .serial_select_n(serial_select_n));
    pdc_core dut (.mclk(mclk), .sys_rst(sys_rst), .serial_clk(serial_clk),
        .serial_data(serial_data), .serial_select_n(serial_select_n),
        .reference_input(reference_input), .vco_input(vco_input),
        .ref_div_monitor(rmon), .vco_div_monitor(vmon),
        .reference_clock_output(rclk), .single_ended_detector_out(se_out),
        .single_ended_detector_oe(se_oe), .ref_side_detector_n(ref_n),
        .vco_side_detector_n(vco_n), .lock_indicator_out(lock));

    // Next value of the random source.
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Output divide factor for each reference clock select code.
    function automatic int divr(input int c);
        int f [8] = '{0, 1, 2, 4, 8, 16, 8, 16};
        return f[c];
    endfunction
    // Chooses which periodic output is measured.
    function automatic logic pick(input int s);
        return (s == 0) ? rmon : ((s == 1) ? vmon : rclk);
    endfunction

    // One cycle, sampled after the registered outputs settle.
    task automatic step(inout int n);
        @(posedge mclk);
        #2;
        n++;
    endtask
    task automatic final_report();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic check_rng(input logic [31:0] got, input int lo, hi_);
        comparisons++;
        if ($isunknown(got) || !(got >= lo && got <= hi_)) begin
            err_count++;
            $display("[FAIL] %0t got %0d outside %0d..%0d", $time, got, lo,
                hi_);
        end
    endtask
    // Sends one frame through the controller and lets the load land.
    task automatic load(input logic [5:0] l, input logic [23:0] w);
        @(posedge mclk);
        #1;
        len = l;
        word = w;
        start = 1'b1;
        @(posedge mclk);
        #1;
        start = 1'b0;
        @(posedge mclk);
        for (int n = 0; n < 400 && busy === 1'b1; n++) @(posedge mclk);
        if (busy === 1'b1) begin
            err_count++;
            $display("[FAIL] %0t frame did not end", $time);
        end
        repeat (4) @(posedge mclk);
    endtask
    // Runs to a rising edge and skips one whole period more, then measures
    // period and high time; a static output reports zero for both.
    task automatic measure(input int s);
        int n;
        n = 0;
        per = 0;
        hi = 0;
        repeat (2) begin
            while (pick(s) === 1'b1 && n < 900) step(n);
            while (pick(s) !== 1'b1 && n < 900) step(n);
        end
        while (pick(s) === 1'b1 && n < 900) begin
            step(n);
            hi++;
        end
        while (pick(s) !== 1'b1 && n < 900) begin
            step(n);
            per++;
        end
        per = (n >= 900) ? 0 : per + hi;
        hi = (n >= 900) ? 0 : hi;
    endtask
    // Counts cycles of each detector, lock and monitor condition.
    task automatic observe(input int cyc);
        int n;
        n = 0;
        {rl, vl, sh, sl, oe, lk, mon} = '0;
        repeat (cyc) begin
            step(n);
            rl += int'(ref_n === 1'b0);
            vl += int'(vco_n === 1'b0);
            sh += int'(se_oe === 1'b1 && se_out === 1'b1);
            sl += int'(se_oe === 1'b1 && se_out === 1'b0);
            oe += int'(se_oe === 1'b1);
            lk += int'(lock === 1'b1);
            mon += int'(rmon === 1'b1 || vmon === 1'b1);
        end
    endtask

    // Main sequence; ratios keep both divided rates far below mclk.
    initial begin
        repeat (4) @(posedge mclk);
        #1 sys_rst = 1'b0;
        observe(300);
        check(mon, 0);
        check(lk, 0);
        check(oe, 0);
        measure(2);
        check(per, 64);
        for (int c = 0; c < 8; c++) begin
            load(6'h08, {16'h0000, 3'b000, 3'(c), 2'b11});
            measure(2);
            check(per, 8 * divr(c));
        end
        for (int k = 0; k < 2; k++) begin
            seed = lfsr(seed);
            rr = 15'(5 + seed[2:0]);
            load((k == 1) ? 6'h18 : 6'h0f, {seed[8:0], rr});
            measure(0);
            check(per, 8 * rr);
            check_rng(hi, 35, 37);
        end
        load(6'h14, 24'h000006);
        measure(0);
        check(per, 8 * rr);
        load(6'h0f, 24'h000001);
        measure(0);
        check(per, 8);
        check(hi, 4);
        seed = lfsr(seed);
        vr = 16'(40 + seed[2:0]);
        load(6'h10, {8'h00, vr});
        measure(1);
        check(per, 4 * vr);
        check(hi, 1);
        // Bit 2 of t makes the divided VCO lead, bit 1 inverts, bit 0
        // selects the single-ended detector.
        for (int t = 0; t < 8; t++) begin
            rh = t[2] ? 8 : 4;
            load(6'h0f, {9'h000, t[2] ? 15'h000c : 15'h0005});
            load(6'h08, {16'h0000, 1'(t >> 1), 1'(t), 6'b110011});
            load(6'h10, 24'h000028);
            observe(1500);
            if (t[0]) begin
                check(rl + vl, 0);
                check(sh > sl, t[2] == t[1]);
            end else begin
                check(oe, 0);
                check(rl > vl, t[2] == t[1]);
            end
            check_rng(lk, 1, 1499);
        end
        // Matched rates, 160 cycles on both sides: lock stays high and the
        // single-ended detector floats except for short phase pulses.
        rh = 4;
        load(6'h0f, {9'h000, 15'h0014});
        load(6'h10, 24'h000028);
        observe(1500);
        check_rng(lk, 1350, 1500);
        check_rng(oe, 0, 150);
        load(6'h09, 24'h000000);
        observe(400);
        check(mon, 0);
        check(lk, 0);
        measure(2);
        check(per, 64);
        final_report();
    end

    // Watchdog at 70,000 cycles, well beyond the expected run of some
    // 20,000 cycles.
    initial begin
        #280000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end
endmodule // tb_pll_divider_phase_detect_core
